// ==== verilog/boost_pkg.sv ====
// Purpose: Shared constants for the step-up converter control registers
// Assumes: 125 MHz system clock
// Notes: Addresses accepted both as full map address and page-0 offset
package boost_pkg;
	localparam logic [15:0] VOUT_ADDR = 16'ha088;
	localparam logic [15:0] CTRL_ADDR = 16'ha089;
	localparam logic [15:0] VOUT_PAGE_ADDR = 16'h0088;
	localparam logic [15:0] CTRL_PAGE_ADDR = 16'h0089;
	localparam logic [7:0] VOUT_RST = 8'h13;
	localparam logic [7:0] CTRL_RST = 8'h0e;
	localparam int EN_BIT = 7;
	localparam int CODE_MSB = 4;
	localparam int CLK_SEL_BIT = 1;
	localparam int ILIM_LSB = 2;
	localparam int OK_BIT = 5;
	localparam logic [1:0] SS_LIMIT = 2'h0;
	localparam int CLK_MHZ = 125;
	localparam int SW_FAST_KHZ = 1000;
	localparam int SW_SLOW_KHZ = 500;
	localparam int SW_FAST_DIV = CLK_MHZ * 1000 / SW_FAST_KHZ;
	localparam int SW_SLOW_DIV = CLK_MHZ * 1000 / SW_SLOW_KHZ;
	localparam int SS_TIME_US = 500;
	localparam int SS_CYCLES = SS_TIME_US * CLK_MHZ;
	typedef enum logic [2:0] {
		ST_OFF = 3'h1,
		ST_SOFT = 3'h2,
		ST_RUN = 3'h4
	} conv_state_t;
endpackage

// ==== verilog/switch_timing_if.sv ====
// Purpose: Link between register logic and switching timer
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/1ps
interface switch_timing_if;
	logic run;
	logic fast_clk;
	logic ss_active;
	logic cycle_pulse;
	modport ctrl (output run, output fast_clk, input ss_active,
		input cycle_pulse);
	modport timer (input run, input fast_clk, output ss_active,
		output cycle_pulse);
endinterface

// ==== verilog/switch_timing.sv ====
// Purpose: Switching-cycle divider and soft-start timer
// Assumes: run is a registered level
// Notes: Divider idles while off to save power
`timescale 1ns/1ps
module switch_timing
	import boost_pkg::*;
#(
	parameter int SS_LEN = SS_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control link
	switch_timing_if.timer t
);
	localparam int SSW = $clog2(SS_LEN + 1);
	conv_state_t state_r;
	logic [SSW-1:0] ss_cnt_r;
	logic [7:0] div_r;
	logic [7:0] div_last;
	logic run_d_r;

	assign div_last = t.fast_clk ? 8'(SW_FAST_DIV - 1) : 8'(SW_SLOW_DIV - 1);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_d_r <= 1'b0;
		end else begin
			run_d_r <= t.run;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_OFF;
			ss_cnt_r <= '0;
		end else if (!t.run) begin
			state_r <= ST_OFF;
			ss_cnt_r <= '0;
		end else if (!run_d_r) begin
			state_r <= ST_SOFT;
			ss_cnt_r <= '0;
		end else begin
			case (state_r)
				ST_SOFT: begin
					if (ss_cnt_r == SSW'(SS_LEN - 1)) begin
						state_r <= ST_RUN;
					end else begin
						ss_cnt_r <= ss_cnt_r + 1'b1;
					end
				end
				ST_RUN: begin
					state_r <= ST_RUN;
				end
				default: begin
					state_r <= ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			t.ss_active <= 1'b0;
		end else begin
			t.ss_active <= t.run && (!run_d_r || state_r != ST_RUN) &&
				!(state_r == ST_SOFT && ss_cnt_r == SSW'(SS_LEN - 1));
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_r <= '0;
			t.cycle_pulse <= 1'b0;
		end else if (!t.run) begin
			div_r <= '0;
			t.cycle_pulse <= 1'b0;
		end else if (div_r >= div_last) begin
			div_r <= '0;
			t.cycle_pulse <= 1'b1;
		end else begin
			div_r <= div_r + 1'b1;
			t.cycle_pulse <= 1'b0;
		end
	end
endmodule

// ==== verilog/boost_regs.sv ====
// Purpose: Control and status registers of the step-up converter
// Assumes: Register strobes synchronous to clk_i; rst_i is power-on reset
// Notes: Analog loop lives outside; this drives its digital settings
//
// What this block does
// - Accept 8-bit writes, apply settings
// - Five-bit code: 4.05 V plus 50 mV/step
// - Voltage register resets to code 19, off
// - Voltage bit 7 is local enable
// - Control bit 1 picks 1.0/0.5 MHz
// - Control bits 3:2 set peak limit
// - Control bit 5 reads output good
// - Run only if global and local enabled
// - Defaults load only at power-on reset
// - Enable rise starts soft-start ramp
// - Limit peak current first 500 us
// - New voltage codes taken while running
// - Limit current each switching cycle
`timescale 1ns/1ps
module boost_regs
	import boost_pkg::*;
#(
	parameter int SS_LEN = SS_CYCLES
) (
	// Clock and power-on reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// System inputs
	input wire logic global_en_i,
	input wire logic out_ok_i,
	// Converter controls
	output logic conv_run_o,
	output logic [4:0] out_voltage_code_o,
	output logic fast_clk_o,
	output logic [1:0] peak_limit_level_o,
	output logic soft_start_o,
	output logic cycle_start_o
);
	logic [7:0] vout_r;
	logic [7:0] ctrl_r;
	logic run_r;
	logic output_ok_flag_r;
	logic [1:0] limit_r;
	logic [1:0] limit_nxt;
	logic hit_vout;
	logic hit_ctrl;
	switch_timing_if tif ();

	assign hit_vout = reg_addr_i == VOUT_ADDR || reg_addr_i == VOUT_PAGE_ADDR;
	assign hit_ctrl = reg_addr_i == CTRL_ADDR || reg_addr_i == CTRL_PAGE_ADDR;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			vout_r <= VOUT_RST;
		end else if (reg_wr_i && hit_vout) begin
			vout_r <= reg_wdata_i;
		end
	end

	// limit field stored
	// Status bit is not storage, so it is held at zero here
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_r <= CTRL_RST;
		end else if (reg_wr_i && hit_ctrl) begin
			ctrl_r <= reg_wdata_i & ~(8'h01 << OK_BIT);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_r <= 1'b0;
		end else begin
			run_r <= global_en_i && vout_r[EN_BIT];
		end
	end

	// output good flag
	// Forced low while off so a stale analog level cannot read good
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			output_ok_flag_r <= 1'b0;
		end else begin
			output_ok_flag_r <= run_r && out_ok_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			if (hit_vout) begin
				reg_rdata_o <= vout_r;
			end else if (hit_ctrl) begin
				reg_rdata_o <= ctrl_r | (8'(output_ok_flag_r) << OK_BIT);
			end else begin
				reg_rdata_o <= 8'h00;
			end
		end
	end

	assign tif.run = run_r;
	assign tif.fast_clk = ctrl_r[CLK_SEL_BIT];

	switch_timing #(
		.SS_LEN(SS_LEN)
	) u_timing (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.t(tif)
	);

	always_comb begin
		limit_nxt = ctrl_r[ILIM_LSB +: 2];
		if (tif.ss_active && limit_nxt > SS_LIMIT) begin
			limit_nxt = SS_LIMIT;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			limit_r <= CTRL_RST[ILIM_LSB +: 2];
		end else begin
			limit_r <= limit_nxt;
		end
	end

	assign out_voltage_code_o = vout_r[CODE_MSB:0];
	assign conv_run_o = run_r;
	assign fast_clk_o = ctrl_r[CLK_SEL_BIT];
	assign peak_limit_level_o = limit_r;
	assign soft_start_o = tif.ss_active;
	assign cycle_start_o = tif.cycle_pulse;
endmodule

// ==== dv/boost_regs_monitor.sv ====
// Purpose: Port checker for boost_regs
// Assumes: One clock, async reset
// Notes: Bound from the bench
`timescale 1ns/1ps
module boost_regs_monitor
	import boost_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// Converter side
	input wire logic global_en_i,
	input wire logic out_ok_i,
	input wire logic conv_run_o,
	input wire logic [4:0] out_voltage_code_o,
	input wire logic fast_clk_o,
	input wire logic [1:0] peak_limit_level_o,
	input wire logic soft_start_o,
	input wire logic cycle_start_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Both the full and the page-0 address reach each register
	wire logic hv = reg_addr_i == VOUT_ADDR ||
		reg_addr_i == VOUT_PAGE_ADDR;
	wire logic hc = reg_addr_i == CTRL_ADDR ||
		reg_addr_i == CTRL_PAGE_ADDR;
	wire logic wv = reg_wr_i && hv;
	wire logic wc = reg_wr_i && hc;
	wire logic rc = reg_rd_i && hc;
	gate_off_a: assert property (!global_en_i |=> !conv_run_o)
		else $error("run without global enable");
	ss_start_a: assert property ($rose(conv_run_o) |=> soft_start_o)
		else $error("no soft-start");
	ss_limit_a: assert property (soft_start_o |=>
		peak_limit_level_o == SS_LIMIT) else $error("limit in soft-start");
	ss_off_a: assert property (!conv_run_o |=> !soft_start_o)
		else $error("soft-start while off");
	code_wr_a: assert property (wv |=>
		out_voltage_code_o == $past(reg_wdata_i[4:0])) else $error("code");
	clk_sel_a: assert property (wc |=>
		fast_clk_o == $past(reg_wdata_i[1])) else $error("clock select");
	// Limit output trails the stored field by one cycle
	lim_wr_a: assert property (wc && !soft_start_o && !conv_run_o |->
		##2 peak_limit_level_o == $past(reg_wdata_i[3:2], 2))
		else $error("limit");
	ok_off_a: assert property (rc && !conv_run_o && !$past(conv_run_o)
		|=> !reg_rdata_o[OK_BIT]) else $error("good flag while off");
	rd_map_a: assert property (reg_rd_i && reg_addr_i[7:1] != 7'h44
		|=> reg_rdata_o == 8'h00) else $error("unmapped read");
	cyc_run_a: assert property (cycle_start_o |-> $past(conv_run_o))
		else $error("switching while off");
	cover property ($fell(soft_start_o));
	cover property (cycle_start_o);
	cover property (wv && reg_wdata_i[EN_BIT]);
endmodule

// ==== dv/boost_regs_tb.sv ====
// Purpose: Bench for boost_regs
// Assumes: Soft-start shortened to 20 cycles
// Notes: Row table, then hand tests
`timescale 1ns/1ps
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module boost_regs_tb
	import boost_pkg::*;
;
	logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
	logic global_en_i = 0, out_ok_i = 0, conv_run_o, fast_clk_o;
	logic soft_start_o, cycle_start_o;
	logic [15:0] reg_addr_i = 0;
	logic [7:0] reg_wdata_i = 0, reg_rdata_o, q;
	logic [4:0] out_voltage_code_o;
	logic [1:0] peak_limit_level_o;
	logic [31:0] rows [6] = '{32'ha088_6a6a, 32'h0088_1313,
		32'ha089_f1d1, 32'h0089_0e0e, 32'h00a0_ff00, 32'ha088_0505};
	int num_errors = 0, checks_done = 0, cyc = 0;
	// Four-state so an unknown pulse cannot count as zero
	logic [31:0] n;
	boost_regs #(.SS_LEN(20)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.global_en_i(global_en_i), .out_ok_i(out_ok_i),
		.conv_run_o(conv_run_o), .out_voltage_code_o(out_voltage_code_o),
		.fast_clk_o(fast_clk_o), .peak_limit_level_o(peak_limit_level_o),
		.soft_start_o(soft_start_o), .cycle_start_o(cycle_start_o)
	);
	initial forever #4 clk_i = ~clk_i;
	// Ceiling well above the few thousand cycles the tests need
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			num_errors++;
			wrap_up;
		end
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge clk_i);
		reg_rd_i <= 1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 0;
		#1 q = reg_rdata_o;
	endtask
	task automatic cnt(input int k);
		n = 0;
		repeat (k) @(posedge clk_i) #1 n += cycle_start_o;
	endtask
	task automatic wrap_up;
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		rd(VOUT_ADDR);
		`CK("vout", 8'h13, q)
		rd(CTRL_ADDR);
		`CK("ctrl", 8'h0e, q)
		foreach (rows[i]) begin
			wr(rows[i][31:16], rows[i][15:8]);
			rd(rows[i][31:16]);
			`CK("row", rows[i][7:0], q)
		end
		global_en_i <= 1;
		out_ok_i <= 1;
		wr(VOUT_ADDR, 8'h93);
		repeat (3) @(posedge clk_i);
		#1 `CK("run", 1'b1, conv_run_o)
		`CK("ss", 1'b1, soft_start_o)
		wr(VOUT_ADDR, 8'h85);
		#1 `CK("code", 5'h05, out_voltage_code_o)
		`CK("ss lim", 2'h0, peak_limit_level_o)
		repeat (15) @(posedge clk_i);
		#1 `CK("ss on", 1'b1, soft_start_o)
		repeat (7) @(posedge clk_i);
		#1 `CK("ss off", 1'b0, soft_start_o)
		`CK("lim", 2'h3, peak_limit_level_o)
		rd(CTRL_ADDR);
		`CK("good", 8'h2e, q)
		cnt(1250);
		`CK("fast", 10, n)
		wr(CTRL_ADDR, 8'h0c);
		// Let the old fast period run out first
		repeat (250) @(posedge clk_i);
		cnt(1250);
		`CK("slow", 5, n)
		global_en_i <= 0;
		repeat (3) @(posedge clk_i);
		#1 `CK("gl off", 1'b0, conv_run_o)
		rd(VOUT_ADDR);
		`CK("keep", 8'h85, q)
		wr(VOUT_ADDR, 8'h05);
		global_en_i <= 1;
		wr(VOUT_ADDR, 8'h85);
		#1 `CK("local off", 1'b0, conv_run_o)
		repeat (2) @(posedge clk_i);
		#1 `CK("restart", 1'b1, soft_start_o)
		rst_i <= 1;
		@(posedge clk_i);
		rst_i <= 0;
		#1 `CK("por", 1'b0, conv_run_o)
		rd(VOUT_ADDR);
		`CK("por vout", 8'h13, q)
		rd(CTRL_ADDR);
		`CK("por ctrl", 8'h0e, q)
		wrap_up;
	end
endmodule
bind boost_regs boost_regs_monitor chk (
	.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.global_en_i(global_en_i), .out_ok_i(out_ok_i),
	.conv_run_o(conv_run_o), .out_voltage_code_o(out_voltage_code_o),
	.fast_clk_o(fast_clk_o), .peak_limit_level_o(peak_limit_level_o),
	.soft_start_o(soft_start_o), .cycle_start_o(cycle_start_o)
);
